// [dv/supply_gpi_control_regs_chk.sv]
// Port assertions for the supply control registers
`timescale 1ns/1ps
`default_nettype none
module supply_gpi_control_regs_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register port
  input wire supply_gpi_pkg::reg_cmd_t reg_cmd,
  input wire supply_gpi_pkg::reg_rsp_t reg_rsp,
  // Pin sources
  input wire logic pin_three_level_bit,
  input wire logic pin_four_level_bit,
  input wire logic supply_fault_indicator,
  input wire logic seq_pin_three,
  // Outputs
  input wire logic pin_three_out,
  input wire logic pin_four_out,
  input wire logic [supply_gpi_pkg::NUM_REGU-1:0] enable_request,
  input wire logic [supply_gpi_pkg::NUM_REGU-1:0] low_power_keep,
  input wire logic linear1_pulldown_connect
);
  import supply_gpi_pkg::*;
  logic [4:0] pf;
  logic w21;
  logic w26;
  // Writes with sequencer enable source
  assign w21 = reg_cmd.write && reg_cmd.addr == OFFSET_SW1 && reg_cmd.wdata[2:1] == 2'h0;
  assign w26 = reg_cmd.write && reg_cmd.addr == OFFSET_LIN1 && reg_cmd.wdata[2:1] == 2'h0;
  // Shadow of the pin function field
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pf <= 5'h00;
    end else if (reg_cmd.write && reg_cmd.addr == OFFSET_PIN_FUNC) begin
      pf <= reg_cmd.wdata[4:0];
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  a_read_answer: assert property (reg_cmd.read |=> reg_rsp.valid)
    else $error("read not answered");
  a_no_spurious: assert property (!reg_cmd.read |=> !reg_rsp.valid)
    else $error("answer without read");
  a_on_bit: assert property (w21 |=> enable_request[0] == $past(reg_cmd.wdata[0]))
    else $error("on bit not applied");
  a_keep_sw: assert property (w21 |=> low_power_keep[0] == $past(reg_cmd.wdata[3]))
    else $error("switcher config wrong");
  a_keep_lin: assert property (w26 |=> low_power_keep[3] == $past(reg_cmd.wdata[7]))
    else $error("linear config wrong");
  a_pd_state: assert property (w26 && !reg_cmd.wdata[0] |=>
    linear1_pulldown_connect != $past(reg_cmd.wdata[3])) else $error("pull-down wrong");
  a_pin4_static: assert property (pf[4:3] == PIN4_STATIC |=>
    pin_four_out == $past(pin_four_level_bit)) else $error("pin 4 static wrong");
  a_pin4_fault: assert property (pf[4:3] == PIN4_FAULT |=> pin_four_out ==
    ($past(supply_fault_indicator) ~^ $past(pin_four_level_bit))) else $error("pin 4 fault");
  a_pin3_seq: assert property (pf[2:0] == PIN3_SEQ |=> pin_three_out ==
    ($past(seq_pin_three) ~^ $past(pin_three_level_bit))) else $error("pin 3 sequencer");
  a_pin3_rsvd: assert property (pf[2:0] == 3'h7 |=> !pin_three_out)
    else $error("pin 3 reserved driven");
  c_read: cover property (reg_rsp.valid);
  c_fwd: cover property (pf[2:0] == PIN3_FWD1);
  c_lin_on: cover property ($rose(enable_request[3]));
endmodule
`default_nettype wire

// [dv/supply_gpi_host.sv]
// Host model driving the register port
`timescale 1ns/1ps
`default_nettype none
module supply_gpi_host (
  // Clock
  input wire logic sys_clk,
  // Register port
  output var supply_gpi_pkg::reg_cmd_t cmd,
  input wire supply_gpi_pkg::reg_rsp_t rsp
);
  import supply_gpi_pkg::*;
  initial cmd = '0;
  // One-cycle write pulse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1 cmd = '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    #1 cmd = '0;
  endtask
  // One-cycle read pulse, answer awaited for two edges
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    #1 cmd = '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk);
    #1 cmd = '0;
    d = 8'hxx;
    for (int k = 0; k < 2 && rsp.valid !== 1'b1; k++) @(posedge sys_clk) #1;
    if (rsp.valid === 1'b1) d = rsp.data;
  endtask
endmodule
`default_nettype wire

// [dv/tb_supply_gpi_control_regs.sv]
// Self-checking bench for the supply control registers
`timescale 1ns/1ps
`default_nettype none
module tb_supply_gpi_control_regs;
  import supply_gpi_pkg::*;
  logic sys_clk, reset_n, lvl3, lvl4, fault, seq3, seq4, pin3, pin4, pd;
  reg_cmd_t reg_cmd;
  reg_rsp_t reg_rsp;
  logic [3:0] general_input, input_polarity, seq_voltage_b;
  logic [3:0] enable_request, voltage_b_select, low_power_keep;
  int fail_count, n_compared;
  logic [7:0] offs [5] = '{OFFSET_SW1, OFFSET_SW2, OFFSET_SW3, OFFSET_LIN1, OFFSET_PIN_FUNC};
  supply_gpi_control_regs dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_cmd(reg_cmd),
    .reg_rsp(reg_rsp), .general_input(general_input), .input_polarity(input_polarity),
    .pin_three_level_bit(lvl3), .pin_four_level_bit(lvl4), .supply_fault_indicator(fault),
    .seq_pin_three(seq3), .seq_pin_four(seq4), .seq_voltage_b(seq_voltage_b),
    .pin_three_out(pin3), .pin_four_out(pin4), .enable_request(enable_request),
    .voltage_b_select(voltage_b_select), .low_power_keep(low_power_keep),
    .linear1_pulldown_connect(pd));
  supply_gpi_host host (.sys_clk(sys_clk), .cmd(reg_cmd), .rsp(reg_rsp));
  // 250 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic end_sim();
    if (fail_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Reset values, reserved bits, unmapped read, config and pull-down
  task automatic t_regs();
    logic [7:0] d;
    logic [7:0] msk [5] = '{MASK_SW, MASK_SW, MASK_SW, MASK_LIN, MASK_PIN_FUNC};
    for (int i = 0; i < 5; i++) begin
      host.rd(offs[i], d);
      chk(d, 8'h00);
      host.wr(offs[i], 8'hff);
      host.rd(offs[i], d);
      chk(d, msk[i]);
    end
    host.rd(8'h20, d);
    chk(d, 8'h00);
    chk({4'h0, low_power_keep}, 8'h0f);
    chk({7'h0, pd}, 8'h00);
    host.wr(OFFSET_LIN1, 8'h00);
    cyc(1);
    chk({7'h0, pd}, 8'h01);
    host.wr(OFFSET_SW1, 8'h09);
    host.wr(OFFSET_LIN1, 8'h88);
    cyc(1);
    chk({4'h0, enable_request}, 8'h07);
    chk({4'h0, low_power_keep}, 8'h0f);
    chk({7'h0, pd}, 8'h00);
  endtask
  // Every output function code of both pins, both level values
  task automatic t_pins();
    logic [2:0] c3;
    logic [1:0] c4;
    logic [7:0] s3;
    logic [3:0] s4;
    logic e3, e4;
    for (int i = 0; i < 16; i++) begin
      c3 = i[3:1];
      c4 = i[2:1];
      lvl3 = i[0];
      lvl4 = i[0];
      fault = ~i[0];
      seq3 = ~i[0];
      seq4 = i[0];
      general_input[2:0] = ~i[2:0];
      host.wr(OFFSET_PIN_FUNC, {3'h0, c4, c3});
      cyc(3);
      s3 = {1'b0, general_input[2:0], seq3, 1'b0, fault, 1'b0};
      s4 = {seq4, 1'b0, fault, 1'b0};
      e3 = (c3 == 0) ? i[0] : (c3 == 2 || c3 == 7) ? 1'b0 : s3[c3] ~^ i[0];
      e4 = (c4 == 0) ? i[0] : (c4 == 2) ? 1'b0 : s4[c4] ~^ i[0];
      chk({6'h0, pin4, pin3}, {6'h0, e4, e3});
    end
  endtask
  // Input edges set enable and voltage, both polarities, then ignored
  task automatic t_edges();
    logic [7:0] d;
    int n;
    seq_voltage_b = 4'hf;
    for (int i = 0; i < 4; i++) begin
      n = i % 3 + 1;
      input_polarity[n] = i[0];
      general_input[n] = ~i[0];
      cyc(4);
      host.wr(offs[i], {1'b0, n[1:0], 2'b00, n[1:0], 1'b0});
      general_input[n] = i[0];
      cyc(4);
      chk({6'h0, enable_request[i], voltage_b_select[i]}, 8'h02);
      host.rd(offs[i], d);
      chk({7'h0, d[0]}, 8'h01);
      general_input[n] = ~i[0];
      cyc(4);
      chk({6'h0, enable_request[i], voltage_b_select[i]}, 8'h01);
      host.wr(offs[i], 8'h00);
      general_input[n] = i[0];
      cyc(4);
      chk({7'h0, enable_request[i]}, 8'h00);
    end
    seq_voltage_b = 4'ha;
    cyc(2);
    chk({4'h0, voltage_b_select}, 8'h0a);
  endtask
  // Main sequence
  initial begin
    fail_count = 0;
    n_compared = 0;
    reset_n = 1'b0;
    general_input = 4'h5;
    input_polarity = 4'hf;
    seq_voltage_b = 4'h0;
    {lvl3, lvl4, seq4} = 3'h0;
    {fault, seq3} = 2'h2;
    repeat (4) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    cyc(3);
    t_regs();
    t_pins();
    t_edges();
    end_sim();
  end
  // Watchdog: tests need a few hundred cycles
  initial begin
    #100000;
    fail_count++;
    end_sim();
  end
endmodule
bind supply_gpi_control_regs supply_gpi_control_regs_chk chk_i (.sys_clk(sys_clk),
  .reset_n(reset_n), .reg_cmd(reg_cmd), .reg_rsp(reg_rsp),
  .pin_three_level_bit(pin_three_level_bit), .pin_four_level_bit(pin_four_level_bit),
  .supply_fault_indicator(supply_fault_indicator), .seq_pin_three(seq_pin_three),
  .pin_three_out(pin_three_out), .pin_four_out(pin_four_out),
  .enable_request(enable_request), .low_power_keep(low_power_keep),
  .linear1_pulldown_connect(linear1_pulldown_connect));
`default_nettype wire

// [rtl/input_edge.sv]
// Synchroniser, polarity and edge detection for one general input pin
`timescale 1ns/1ps
`default_nettype none
module input_edge (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Pin and its polarity
  input wire logic pin,
  input wire logic polarity,
  // Active level and edge pulses
  output logic active,
  output logic rise,
  output logic fall
);
  import supply_gpi_pkg::*;

  edge_state_t s;
  edge_state_t next_s;

  // ----------------------------------------------------------------
  // Next state: two flops, then polarity
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.meta = pin;
    next_s.sync = s.meta;
    next_s.active = polarity ? s.sync : ~s.sync;
  end

  // State register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Passive-to-active and active-to-passive pulses
  assign active = s.active;
  assign rise = next_s.active & ~s.active;
  assign fall = ~next_s.active & s.active;
endmodule
`default_nettype wire

// [rtl/supply_gpi_control_regs.sv]
// Pin output functions and regulator enable/voltage control registers
`timescale 1ns/1ps
`default_nettype none
module supply_gpi_control_regs (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register access from the two-wire interface
  input wire supply_gpi_pkg::reg_cmd_t reg_cmd,
  output supply_gpi_pkg::reg_rsp_t reg_rsp,
  // General input pins and their polarity bits
  input wire logic [supply_gpi_pkg::NUM_INPUTS-1:0] general_input,
  input wire logic [supply_gpi_pkg::NUM_INPUTS-1:0] input_polarity,
  // Pin level bits
  input wire logic pin_three_level_bit,
  input wire logic pin_four_level_bit,
  // Supply monitor and sequencer
  input wire logic supply_fault_indicator,
  input wire logic seq_pin_three,
  input wire logic seq_pin_four,
  input wire logic [supply_gpi_pkg::NUM_REGU-1:0] seq_voltage_b,
  // Pin outputs
  output logic pin_three_out,
  output logic pin_four_out,
  // Regulator controls
  output logic [supply_gpi_pkg::NUM_REGU-1:0] enable_request,
  output logic [supply_gpi_pkg::NUM_REGU-1:0] voltage_b_select,
  output logic [supply_gpi_pkg::NUM_REGU-1:0] low_power_keep,
  output logic linear1_pulldown_connect
);
  import supply_gpi_pkg::*;

  ctrl_state_t s;
  ctrl_state_t next_s;
  logic [NUM_INPUTS-1:0] in_active;
  logic [NUM_INPUTS-1:0] in_rise;
  logic [NUM_INPUTS-1:0] in_fall;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Edge from the input chosen by a source field, none for sequencer
  function automatic logic pick_edge(input logic [1:0] src,
                                     input logic [NUM_INPUTS-1:0] ev);
    logic r;
    r = 1'b0;
    if (src != SRC_SEQUENCER) begin
      r = ev[src];
    end
    return r;
  endfunction

  // Offset of a regulator control register
  function automatic logic [7:0] regu_offset(input int idx);
    logic [7:0] r;
    r = OFFSET_LIN1;
    case (idx)
      IDX_SW1: r = OFFSET_SW1;
      IDX_SW2: r = OFFSET_SW2;
      IDX_SW3: r = OFFSET_SW3;
      default: r = OFFSET_LIN1;
    endcase
    return r;
  endfunction

  // Writable bits of a regulator control register
  function automatic logic [7:0] regu_mask(input int idx);
    return (idx == IDX_LIN1) ? MASK_LIN : MASK_SW;
  endfunction

  // Non-static output: level bit sets the polarity
  function automatic logic apply_level(input logic lvl, input logic act);
    return lvl ? act : ~act;
  endfunction

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Source fields reach inputs 1 to 3; keep bits name four regulators
  if (NUM_INPUTS < 4) begin : g_bad_inputs
    $error("general input count too small for the source fields");
  end
  if (NUM_REGU != 4) begin : g_bad_regu
    $error("regulator count must be four");
  end

  // ----------------------------------------------------------------
  // General input conditioning
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_INPUTS; g++) begin : g_in
    input_edge u_edge (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .pin(general_input[g]),
      .polarity(input_polarity[g]),
      .active(in_active[g]),
      .rise(in_rise[g]),
      .fall(in_fall[g])
    );
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.rsp.valid = 1'b0;

    // Software writes, reserved bits kept at zero
    if (reg_cmd.write) begin
      if (reg_cmd.addr == OFFSET_PIN_FUNC) begin
        next_s.pin_func = reg_cmd.wdata & MASK_PIN_FUNC;
      end
      for (int i = 0; i < NUM_REGU; i++) begin
        if (reg_cmd.addr == regu_offset(i)) begin
          next_s.regu[i] = reg_cmd.wdata & regu_mask(i);
        end
      end
    end

    // Input edges rewrite the enable bit; hardware wins over a write
    for (int i = 0; i < NUM_REGU; i++) begin
      if (pick_edge(s.regu[i][ESRC_LSB +: 2], in_rise)) begin
        next_s.regu[i][ON_BIT] = 1'b1;
      end else if (pick_edge(s.regu[i][ESRC_LSB +: 2], in_fall)) begin
        next_s.regu[i][ON_BIT] = 1'b0;
      end
    end

    // Voltage setting: sequencer or edges of the chosen input
    for (int i = 0; i < NUM_REGU; i++) begin
      if (s.regu[i][VSRC_LSB +: 2] == SRC_SEQUENCER) begin
        next_s.volt_b[i] = seq_voltage_b[i];
      end else if (pick_edge(s.regu[i][VSRC_LSB +: 2], in_rise)) begin
        next_s.volt_b[i] = 1'b0;
      end else if (pick_edge(s.regu[i][VSRC_LSB +: 2], in_fall)) begin
        next_s.volt_b[i] = 1'b1;
      end
    end

    // Enable requests go to the sequencer, which orders them
    for (int i = 0; i < NUM_REGU; i++) begin
      next_s.en_req[i] = next_s.regu[i][ON_BIT];
    end

    // Default supply or kept on in low power
    next_s.keep[IDX_SW1] = next_s.regu[IDX_SW1][SW_CFG_BIT];
    next_s.keep[IDX_SW2] = next_s.regu[IDX_SW2][SW_CFG_BIT];
    next_s.keep[IDX_SW3] = next_s.regu[IDX_SW3][SW_CFG_BIT];
    next_s.keep[IDX_LIN1] = next_s.regu[IDX_LIN1][LIN_CFG_BIT];

    // Pull-down only while off and not disabled
    next_s.pd_connect = ~next_s.regu[IDX_LIN1][ON_BIT]
                        & ~next_s.regu[IDX_LIN1][LIN_PD_OFF_BIT];

    // Pin 4 output function, reserved code drives low
    case (s.pin_func[PIN4_LSB +: 2])
      PIN4_STATIC: next_s.pin4 = pin_four_level_bit;
      PIN4_FAULT: next_s.pin4 = apply_level(pin_four_level_bit, supply_fault_indicator);
      PIN4_SEQ: next_s.pin4 = apply_level(pin_four_level_bit, seq_pin_four);
      default: next_s.pin4 = 1'b0;
    endcase

    // Pin 3 output function, reserved codes drive low
    case (s.pin_func[PIN3_LSB +: 3])
      PIN3_STATIC: next_s.pin3 = pin_three_level_bit;
      PIN3_FAULT: next_s.pin3 = apply_level(pin_three_level_bit, supply_fault_indicator);
      PIN3_SEQ: next_s.pin3 = apply_level(pin_three_level_bit, seq_pin_three);
      PIN3_FWD0: next_s.pin3 = apply_level(pin_three_level_bit, in_active[0]);
      PIN3_FWD1: next_s.pin3 = apply_level(pin_three_level_bit, in_active[1]);
      PIN3_FWD2: next_s.pin3 = apply_level(pin_three_level_bit, in_active[2]);
      default: next_s.pin3 = 1'b0;
    endcase

    // Read answer one cycle after the request
    if (reg_cmd.read) begin
      next_s.rsp.valid = 1'b1;
      next_s.rsp.data = READ_UNMAPPED;
      if (reg_cmd.addr == OFFSET_PIN_FUNC) begin
        next_s.rsp.data = s.pin_func;
      end
      for (int i = 0; i < NUM_REGU; i++) begin
        if (reg_cmd.addr == regu_offset(i)) begin
          next_s.rsp.data = s.regu[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.pin_func <= RESET_PIN_FUNC;
      s.regu <= {NUM_REGU{RESET_REGU}};
      s.pd_connect <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign reg_rsp = s.rsp;
  assign pin_three_out = s.pin3;
  assign pin_four_out = s.pin4;
  assign enable_request = s.en_req;
  assign voltage_b_select = s.volt_b;
  assign low_power_keep = s.keep;
  assign linear1_pulldown_connect = s.pd_connect;
endmodule
`default_nettype wire

// [rtl/supply_gpi_pkg.sv]
// Constants, field layouts and carrier types for the supply and pin control registers
package supply_gpi_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFFSET_PIN_FUNC = 8'h1f;
  localparam logic [7:0] OFFSET_SW1 = 8'h21;
  localparam logic [7:0] OFFSET_SW3 = 8'h22;
  localparam logic [7:0] OFFSET_SW2 = 8'h24;
  localparam logic [7:0] OFFSET_LIN1 = 8'h26;

  // ----------------------------------------------------------------
  // Regulator indices
  // ----------------------------------------------------------------
  localparam int NUM_REGU = 4;
  localparam int IDX_SW1 = 0;
  localparam int IDX_SW2 = 1;
  localparam int IDX_SW3 = 2;
  localparam int IDX_LIN1 = 3;
  localparam int NUM_INPUTS = 4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int VSRC_LSB = 5;
  localparam int ESRC_LSB = 1;
  localparam int ON_BIT = 0;
  localparam int SW_CFG_BIT = 3;
  localparam int LIN_CFG_BIT = 7;
  localparam int LIN_PD_OFF_BIT = 3;
  localparam int PIN4_LSB = 3;
  localparam int PIN3_LSB = 0;

  // ----------------------------------------------------------------
  // Writable bits and reset values (reserved bits stay zero)
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_PIN_FUNC = 8'h1f;
  localparam logic [7:0] MASK_SW = 8'h6f;
  localparam logic [7:0] MASK_LIN = 8'hef;
  localparam logic [7:0] RESET_PIN_FUNC = 8'h00;
  localparam logic [7:0] RESET_REGU = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // Source and output-function codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_SEQUENCER = 2'h0;
  localparam logic [1:0] PIN4_STATIC = 2'h0;
  localparam logic [1:0] PIN4_FAULT = 2'h1;
  localparam logic [1:0] PIN4_SEQ = 2'h3;
  localparam logic [2:0] PIN3_STATIC = 3'h0;
  localparam logic [2:0] PIN3_FAULT = 3'h1;
  localparam logic [2:0] PIN3_SEQ = 3'h3;
  localparam logic [2:0] PIN3_FWD0 = 3'h4;
  localparam logic [2:0] PIN3_FWD1 = 3'h5;
  localparam logic [2:0] PIN3_FWD2 = 3'h6;

  // ----------------------------------------------------------------
  // Carrier and state types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } reg_cmd_t;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } reg_rsp_t;

  typedef struct packed {
    logic meta;
    logic sync;
    logic active;
  } edge_state_t;

  typedef struct packed {
    logic [7:0] pin_func;
    logic [NUM_REGU-1:0][7:0] regu;
    logic [NUM_REGU-1:0] volt_b;
    logic [NUM_REGU-1:0] en_req;
    logic [NUM_REGU-1:0] keep;
    logic pd_connect;
    logic pin3;
    logic pin4;
    reg_rsp_t rsp;
  } ctrl_state_t;

endpackage
